// File: pkg/gpp_pkg.sv
// gpp_pkg: register indices, reset values and decode for the port block
// assumes a 32-bit axi4-lite slave; byte address = 4 * register index
package gpp_pkg;

  // bus widths
  localparam int ADDR_W = 18;              // byte address width
  localparam int DATA_W = 32;              // axi data width
  localparam int PAD_W  = 24;              // zero bits above a byte

  // register indices (byte address is four times these)
  localparam logic [15:0] IDX_DIR0  = 16'hff20; // port0_direction
  localparam logic [15:0] IDX_DIR1  = 16'hff21; // port1_direction
  localparam logic [15:0] IDX_DIR4  = 16'hff24; // port4_direction
  localparam logic [15:0] IDX_DIR6  = 16'hff26; // port6_direction
  localparam logic [15:0] IDX_PULL  = 16'hfff7; // pullup_option
  localparam logic [15:0] IDX_SEG   = 16'hff58; // segment_function_select
  localparam logic [15:0] IDX_LAT0  = 16'hff00; // port 0 data
  localparam logic [15:0] IDX_LAT1  = 16'hff01; // port 1 data
  localparam logic [15:0] IDX_LAT4  = 16'hff04; // port 4 data
  localparam logic [15:0] IDX_LAT6  = 16'hff06; // port 6 data
  localparam logic [15:0] IDX_PORT8 = 16'hff08; // port 8 pins, read only

  // reset values and masks
  localparam logic [7:0] DIR_RST   = 8'hff;  // all inputs
  localparam logic [7:0] PULL_RST  = 8'h00;  // no pull-ups
  localparam logic [7:0] SEG_RST   = 8'h00;  // all general inputs
  localparam logic [7:0] LATCH_RST = 8'h00;  // output latches
  localparam logic [7:0] PULL_MASK = 8'h13;  // bits 0, 1 and 4 exist
  localparam logic [7:0] SEG_MASK  = 8'h3f;  // bits 0 to 5 exist

  // field positions
  localparam int PU_G0   = 0;              // group 0 pull-up enable
  localparam int PU_G1   = 1;              // group 1 pull-up enable
  localparam int PU_G4   = 4;              // group 4 pull-up enable
  localparam int IRQ_BIT = 1;              // port 6 bit shared with irq
  localparam int TMR_BIT = 0;              // port 6 bit shared with timer

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register selector
  typedef enum logic [3:0] {
    REG_NONE  = 4'h0,
    REG_DIR0  = 4'h1,
    REG_DIR1  = 4'h2,
    REG_DIR4  = 4'h3,
    REG_DIR6  = 4'h4,
    REG_PULL  = 4'h5,
    REG_SEG   = 4'h6,
    REG_LAT0  = 4'h7,
    REG_LAT1  = 4'h8,
    REG_LAT4  = 4'h9,
    REG_LAT6  = 4'ha,
    REG_PORT8 = 4'hb
  } gpp_reg_t;

  // address decode, shared by the read and write paths
  function automatic gpp_reg_t gpp_decode(input logic [ADDR_W-1:0] a);
    logic [15:0] idx;
    idx = a[ADDR_W-1:2];
    if (a[1:0] != 2'h0) return REG_NONE;
    unique case (idx)
      IDX_DIR0:  return REG_DIR0;
      IDX_DIR1:  return REG_DIR1;
      IDX_DIR4:  return REG_DIR4;
      IDX_DIR6:  return REG_DIR6;
      IDX_PULL:  return REG_PULL;
      IDX_SEG:   return REG_SEG;
      IDX_LAT0:  return REG_LAT0;
      IDX_LAT1:  return REG_LAT1;
      IDX_LAT4:  return REG_LAT4;
      IDX_LAT6:  return REG_LAT6;
      IDX_PORT8: return REG_PORT8;
      default:   return REG_NONE;
    endcase
  endfunction

endpackage

// File: rtl/gpp_sync.sv
// gpp_sync: two-flop synchroniser for asynchronous pin levels
// assumes one clock; clock enable freezes both stages
`timescale 1ns/1ns
`default_nettype none
module gpp_sync #(
  parameter int W = 18
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;  // first stage, read only by dout

  // metastability guard; reset clears both stages
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // gpp_sync
`default_nettype wire

// File: rtl/gpp_port.sv
// gpp_port: one bidirectional port: latch, direction, pad drive, pull-ups
// assumes synchronised pin levels and byte writes from the bus slave
`timescale 1ns/1ns
`default_nettype none
module gpp_port #(
  parameter int W = 4
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [7:0]   wr_data,
  input  wire logic         latch_we,
  input  wire logic         dir_we,
  input  wire logic [W-1:0] pins,
  input  wire logic [W-1:0] alt_out,
  input  wire logic         group_pullup,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pu_en,
  output logic      [W-1:0] latch,
  output logic      [W-1:0] dir,
  output logic      [W-1:0] rd_port
);

  logic [W-1:0] next_latch;  // latch after a write
  logic [W-1:0] next_dir;    // direction after a write

  // latch takes writes even in input mode; pin is untouched then
  assign next_latch = latch_we ? wr_data[W-1:0] : latch; // R19
  assign next_dir   = dir_we ? wr_data[W-1:0] : dir;     // R09
  // output bits read the latch, input bits the pin
  assign rd_port = (dir & pins) | (~dir & latch);        // R18

  // state and pad drive, all registered
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      latch   <= gpp_pkg::LATCH_RST[W-1:0];
      dir     <= gpp_pkg::DIR_RST[W-1:0];  // R07
      pin_out <= gpp_pkg::LATCH_RST[W-1:0];
      pin_oe  <= '0;
      pu_en   <= '0;
    end else if (ce) begin
      latch   <= next_latch;
      dir     <= next_dir;
      pin_out <= next_latch | alt_out;
      pin_oe  <= ~next_dir;                          // R08
      pu_en   <= {W{group_pullup}} & next_dir;       // R14
    end
  end

endmodule // gpp_port
`default_nettype wire

// File: rtl/gpp_top.sv
// gpp_top: general-purpose ports 0, 1, 4, 6 and input port 8
// assumes an axi4-lite master on clock; pins arrive asynchronously
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// (R01) eighteen pins, twelve bidirectional, ten pull-ups
// (R02) port 0: four bits, latch, per-bit direction
// (R03) port 1: two bits, latch, per-bit direction
// (R04) port 4: four bits, also feeds key return
// (R05) port 6: timer, interrupt, analog; no pull-ups
// (R06) port 8: six inputs, per-bit segment select
// (R07) direction registers reset to all ones
// (R08) direction 0 drives pin, 1 releases it
// (R09) direction registers writable by byte or bit
// (R10) software sets alternate-function pins per table
// (R11) output change on irq pin raises request
// (R12) software masks irq before driving that pin
// (R13) pull-up enables: bit0 port0, bit1, bit4
// (R14) pull-up only on enabled input-mode bits
// (R15) pull-up option resets zero, byte/bit writable
// (R16) software writes zero to unused pull-up bits
// (R17) unimplemented direction bits read one, ignore writes
// (R18) port read: latch if output, pin if input
// (R19) write in input mode updates latch only
// (R20) segment select: 0 port, 1 segment; reset zero
module gpp_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // axi4-lite write address
  input  wire logic [17:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [17:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // port 0 pins
  input  wire logic [3:0]  port0_pin_in,
  output logic      [3:0]  port0_pin_out,
  output logic      [3:0]  port0_pin_oe,
  output logic      [3:0]  port0_pullup,
  // port 1 pins
  input  wire logic [1:0]  port1_pin_in,
  output logic      [1:0]  port1_pin_out,
  output logic      [1:0]  port1_pin_oe,
  output logic      [1:0]  port1_pullup,
  // port 4 pins
  input  wire logic [3:0]  port4_pin_in,
  output logic      [3:0]  port4_pin_out,
  output logic      [3:0]  port4_pin_oe,
  output logic      [3:0]  port4_pullup,
  // port 6 pins
  input  wire logic [1:0]  port6_pin_in,
  output logic      [1:0]  port6_pin_out,
  output logic      [1:0]  port6_pin_oe,
  // port 8 pins
  input  wire logic [5:0]  port8_pin_in,
  output logic      [5:0]  port8_pin_out,
  output logic      [5:0]  port8_pin_oe,
  // alternate-function paths
  input  wire logic        timer_output_pin,
  input  wire logic        analog_select_bit,
  input  wire logic [5:0]  segment_data,
  output logic      [3:0]  key_return_inputs,
  output logic             external_interrupt_input,
  output logic             ext_irq_request,
  output logic             analog_input_channel
);

  // ---- pin synchronisers
  // all eighteen pin inputs pass two flops before any logic
  logic [17:0] pins_async;   // raw pin levels, packed
  logic [17:0] pins_sync;    // synchronised levels
  logic [3:0]  pin0_s;       // port 0 levels
  logic [1:0]  pin1_s;       // port 1 levels
  logic [3:0]  pin4_s;       // port 4 levels
  logic [1:0]  pin6_s;       // port 6 levels
  logic [5:0]  pin8_s;       // port 8 levels

  // eighteen pins in total
  assign pins_async = {port8_pin_in, port6_pin_in, port4_pin_in,
                       port1_pin_in, port0_pin_in}; // R01
  assign pin0_s = pins_sync[3:0];
  assign pin1_s = pins_sync[5:4];
  assign pin4_s = pins_sync[9:6];
  assign pin6_s = pins_sync[11:10];
  assign pin8_s = pins_sync[17:12];

  gpp_sync #(
    .W (18)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .din   (pins_async),
    .dout  (pins_sync)
  );

  // ---- write channel state
  logic [17:0] aw_addr_q;    // captured write address
  logic        aw_full;      // address held
  logic        w_full;       // data held
  logic [7:0]  w_byte_q;     // low data byte
  logic        w_lane_q;     // low byte lane enabled

  // ---- register state kept here
  logic [7:0]  pullup_option;            // group pull-up enables
  logic [5:0]  segment_function_select;  // port 8 function bits

  // ---- decode
  gpp_pkg::gpp_reg_t wr_sel;  // target of the held write
  gpp_pkg::gpp_reg_t rd_sel;  // target of the offered read
  logic        write_fire;    // both halves held, no response pending
  logic        wr_en;         // fire with the low lane enabled
  logic        we_dir0;
  logic        we_dir1;
  logic        we_dir4;
  logic        we_dir6;
  logic        we_lat0;
  logic        we_lat1;
  logic        we_lat4;
  logic        we_lat6;
  logic        we_pull;
  logic        we_seg;
  logic        aw_take;       // write address handshake
  logic        w_take;        // write data handshake
  logic        ar_take;       // read address handshake

  assign aw_take    = awvalid & awready;
  assign w_take     = wvalid & wready;
  assign ar_take    = arvalid & arready;
  assign write_fire = aw_full & w_full & ~bvalid;
  assign wr_sel     = gpp_pkg::gpp_decode(aw_addr_q);
  assign rd_sel     = gpp_pkg::gpp_decode(araddr);
  // a write with byte lane 0 off stores nothing
  assign wr_en      = write_fire & w_lane_q;
  assign we_dir0 = wr_en & (wr_sel == gpp_pkg::REG_DIR0); // R09
  assign we_dir1 = wr_en & (wr_sel == gpp_pkg::REG_DIR1); // R09
  assign we_dir4 = wr_en & (wr_sel == gpp_pkg::REG_DIR4); // R09
  assign we_dir6 = wr_en & (wr_sel == gpp_pkg::REG_DIR6); // R09
  assign we_lat0 = wr_en & (wr_sel == gpp_pkg::REG_LAT0);
  assign we_lat1 = wr_en & (wr_sel == gpp_pkg::REG_LAT1);
  assign we_lat4 = wr_en & (wr_sel == gpp_pkg::REG_LAT4);
  assign we_lat6 = wr_en & (wr_sel == gpp_pkg::REG_LAT6);
  assign we_pull = wr_en & (wr_sel == gpp_pkg::REG_PULL); // R15
  assign we_seg  = wr_en & (wr_sel == gpp_pkg::REG_SEG);

  // ---- ports
  logic [3:0] lat0, dir0, rd0;  // port 0 latch, direction, read
  logic [1:0] lat1, dir1, rd1;  // port 1
  logic [3:0] lat4, dir4, rd4;  // port 4
  logic [1:0] lat6, dir6, rd6;  // port 6
  logic [1:0] alt6;             // port 6 alternate drive

  // timer output ors with latch bit 0 onto the pin drive; software keeps latch 0 then
  assign alt6 = {1'b0, timer_output_pin};

  gpp_port #(
    .W (4)
  ) u_port0 (                                   // R02
    .clock        (clock),
    .rst_n        (rst_n),
    .ce           (ce),
    .wr_data      (w_byte_q),
    .latch_we     (we_lat0),
    .dir_we       (we_dir0),
    .pins         (pin0_s),
    .alt_out      (4'h0),
    .group_pullup (pullup_option[gpp_pkg::PU_G0]), // R13
    .pin_out      (port0_pin_out),
    .pin_oe       (port0_pin_oe),
    .pu_en        (port0_pullup),
    .latch        (lat0),
    .dir          (dir0),
    .rd_port      (rd0)
  );

  gpp_port #(
    .W (2)
  ) u_port1 (                                   // R03
    .clock        (clock),
    .rst_n        (rst_n),
    .ce           (ce),
    .wr_data      (w_byte_q),
    .latch_we     (we_lat1),
    .dir_we       (we_dir1),
    .pins         (pin1_s),
    .alt_out      (2'h0),
    .group_pullup (pullup_option[gpp_pkg::PU_G1]), // R13
    .pin_out      (port1_pin_out),
    .pin_oe       (port1_pin_oe),
    .pu_en        (port1_pullup),
    .latch        (lat1),
    .dir          (dir1),
    .rd_port      (rd1)
  );

  gpp_port #(
    .W (4)
  ) u_port4 (                                   // R04
    .clock        (clock),
    .rst_n        (rst_n),
    .ce           (ce),
    .wr_data      (w_byte_q),
    .latch_we     (we_lat4),
    .dir_we       (we_dir4),
    .pins         (pin4_s),
    .alt_out      (4'h0),
    .group_pullup (pullup_option[gpp_pkg::PU_G4]), // R13
    .pin_out      (port4_pin_out),
    .pin_oe       (port4_pin_oe),
    .pu_en        (port4_pullup),
    .latch        (lat4),
    .dir          (dir4),
    .rd_port      (rd4)
  );

  // port 6 has no pull-ups: group tied off, output left open
  gpp_port #(
    .W (2)
  ) u_port6 (                                   // R05
    .clock        (clock),
    .rst_n        (rst_n),
    .ce           (ce),
    .wr_data      (w_byte_q),
    .latch_we     (we_lat6),
    .dir_we       (we_dir6),
    .pins         (pin6_s),
    .alt_out      (alt6),
    .group_pullup (1'b0),
    .pin_out      (port6_pin_out),
    .pin_oe       (port6_pin_oe),
    .pu_en        (),
    .latch        (lat6),
    .dir          (dir6),
    .rd_port      (rd6)
  );

  // ---- read mux
  logic [7:0] rd_byte;     // selected register byte
  logic       rd_hit;      // address maps to a register
  logic [7:0] rd_dir0;     // directions with unused bits at one
  logic [7:0] rd_dir1;
  logic [7:0] rd_dir4;
  logic [7:0] rd_dir6;

  // unused direction positions read one and are never stored
  assign rd_dir0 = {gpp_pkg::DIR_RST[7:4], dir0}; // R17
  assign rd_dir1 = {gpp_pkg::DIR_RST[7:2], dir1}; // R17
  assign rd_dir4 = {gpp_pkg::DIR_RST[7:4], dir4}; // R17
  assign rd_dir6 = {gpp_pkg::DIR_RST[7:2], dir6}; // R17
  assign rd_hit  = (rd_sel != gpp_pkg::REG_NONE);
  // data reads of ports 0, 1, 4 and 6 take pin or latch per bit inside each port; port 8 reads its pins
  assign rd_byte =
    (rd_sel == gpp_pkg::REG_DIR0)  ? rd_dir0 :
    (rd_sel == gpp_pkg::REG_DIR1)  ? rd_dir1 :
    (rd_sel == gpp_pkg::REG_DIR4)  ? rd_dir4 :
    (rd_sel == gpp_pkg::REG_DIR6)  ? rd_dir6 :
    (rd_sel == gpp_pkg::REG_PULL)  ? pullup_option :
    (rd_sel == gpp_pkg::REG_SEG)   ? {2'h0, segment_function_select} :
    (rd_sel == gpp_pkg::REG_LAT0)  ? {4'h0, rd0} :   // R18
    (rd_sel == gpp_pkg::REG_LAT1)  ? {6'h00, rd1} :  // R18
    (rd_sel == gpp_pkg::REG_LAT4)  ? {4'h0, rd4} :   // R18
    (rd_sel == gpp_pkg::REG_LAT6)  ? {6'h00, rd6} :  // R18
    (rd_sel == gpp_pkg::REG_PORT8) ? {2'h0, pin8_s} :
    8'h00;

  // ---- write channel: address and data taken in either order
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awready   <= 1'b1;
      aw_full   <= 1'b0;
      aw_addr_q <= '0;
    end else if (ce) begin
      if (aw_take) begin
        aw_addr_q <= awaddr;
        aw_full   <= 1'b1;
        awready   <= 1'b0;
      end else if (write_fire) begin
        aw_full   <= 1'b0;
      end
      // reopen only after the response leaves
      if (bvalid && bready) begin
        awready <= 1'b1;
      end
    end
  end

  // data half of the write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wready   <= 1'b1;
      w_full   <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (ce) begin
      if (w_take) begin
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
        w_full   <= 1'b1;
        wready   <= 1'b0;
      end else if (write_fire) begin
        w_full   <= 1'b0;
      end
      if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= gpp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (write_fire) begin
        bvalid <= 1'b1;
        bresp  <= (wr_sel == gpp_pkg::REG_NONE) ?
                  gpp_pkg::RESP_SLVERR : gpp_pkg::RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ---- read channel: one read at a time, data one cycle later
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= gpp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {{gpp_pkg::PAD_W{1'b0}}, rd_byte};
        rresp   <= rd_hit ? gpp_pkg::RESP_OKAY : gpp_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ---- pull-up option and segment select
  // unused pull-up bits are not stored, so they read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pullup_option           <= gpp_pkg::PULL_RST;        // R15
      segment_function_select <= gpp_pkg::SEG_RST[5:0];    // R20
    end else if (ce) begin
      if (we_pull) begin
        pullup_option <= w_byte_q & gpp_pkg::PULL_MASK;    // R13
      end
      if (we_seg) begin
        segment_function_select <= w_byte_q[5:0];          // R20
      end
    end
  end

  // ---- port 8 and alternate functions
  logic next_irq_level;  // level seen by the interrupt input

  // in output mode the latch is what the pin shows, so a latch
  // change reaches the interrupt edge logic as on silicon
  assign next_irq_level =
    (dir6[gpp_pkg::IRQ_BIT] ? pin6_s[gpp_pkg::IRQ_BIT]
                            : lat6[gpp_pkg::IRQ_BIT])
    & ~analog_select_bit;

  // registered alternate paths and segment drive
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port8_pin_out            <= 6'h00;
      port8_pin_oe             <= 6'h00;
      key_return_inputs        <= 4'h0;
      external_interrupt_input <= 1'b0;
      ext_irq_request          <= 1'b0;
      analog_input_channel     <= 1'b0;
    end else if (ce) begin
      // select 1 drives the segment, 0 leaves an input
      port8_pin_out <= segment_data;                       // R06
      port8_pin_oe  <= segment_function_select;            // R20
      key_return_inputs        <= rd4;                     // R04
      external_interrupt_input <= next_irq_level;
      // any level change, including a driven one, requests
      ext_irq_request <= next_irq_level
                         ^ external_interrupt_input;       // R11
      analog_input_channel <= pin6_s[gpp_pkg::IRQ_BIT]
                              & analog_select_bit;
    end
  end

endmodule // gpp_top
`default_nettype wire

// File: verif/gpp_pad.sv
// gpp_pad: board side of one group of port pins
// assumes the bench chooses whether an outside driver is present
`timescale 1ns/1ns
`default_nettype none
module gpp_pad #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] dout,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] ext,
  input  wire logic         en,
  output logic      [W-1:0] lvl
);
  // device drive wins, then outside driver, then pull-up;
  // a floating bit shows the inverse of the outside value
  assign lvl = (oe & dout) | (~oe & (en ? ext : (pu | ~ext)));
endmodule // gpp_pad
`default_nettype wire

// File: verif/gpp_chk_sva.sv
// gpp_chk_sva: port and bus checks on the top ports
// assumes one clock domain; bound into every gpp_top
`timescale 1ns/1ns
`default_nettype none
module gpp_chk (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic [3:0]  port0_pin_oe,
  input wire logic [3:0]  port0_pullup,
  input wire logic [1:0]  port1_pin_oe,
  input wire logic [1:0]  port1_pullup,
  input wire logic [3:0]  port4_pin_oe,
  input wire logic [3:0]  port4_pullup,
  input wire logic [5:0]  port8_pin_oe,
  input wire logic        external_interrupt_input,
  input wire logic        ext_irq_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // port 0, 4 and 8 pins released right after reset
  chk_reset_quiet: assert property ($rose(rst_n) |->
    port0_pin_oe == 0 && port4_pin_oe == 0 && port8_pin_oe == 0)
    else $error("pin driven after reset");
  // port 0 and 4 output-mode bits never carry a pull-up
  chk_pull_oe: assert property (
    ((port0_pullup & port0_pin_oe) | (port4_pullup & port4_pin_oe)) == 0)
    else $error("pull-up on output bit");
  // a group is either fully off or on every input bit
  chk_group0: assert property (
    port0_pullup == 0 || port0_pullup == ~port0_pin_oe)
    else $error("port 0 pull-up group broken");
  chk_group1: assert property (
    port1_pullup == 0 || port1_pullup == ~port1_pin_oe)
    else $error("port 1 pull-up group broken");
  // level change on the shared pin raises a request
  chk_irq_edge: assert property (
    $changed(external_interrupt_input) |-> ##[0:1] ext_irq_request)
    else $error("missing interrupt request");
  chk_b_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  chk_aw_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  chk_r_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response late");
  chk_r_upper: assert property (rvalid |-> rdata[31:8] == 0)
    else $error("read data upper bits set");
endmodule // gpp_chk
bind gpp_top gpp_chk u_chk (.*);
`default_nettype wire

// File: verif/tb_top.sv
// tb_top: register and pin tests of the port block
// assumes gpp_pad on every bidirectional group
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clock = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'h1, ext = 4'h9;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [3:0]  port0_pin_in, port0_pin_out, port0_pin_oe, port0_pullup;
  logic [1:0]  port1_pin_in, port1_pin_out, port1_pin_oe, port1_pullup;
  logic [3:0]  port4_pin_in, port4_pin_out, port4_pin_oe, port4_pullup;
  logic [1:0]  port6_pin_in, port6_pin_out, port6_pin_oe;
  logic [5:0]  port8_pin_in = 6'h2a, port8_pin_out, port8_pin_oe;
  logic [5:0]  segment_data = 6'h15;
  logic        timer_output_pin = 1'b0, analog_select_bit = 1'b0;
  logic [3:0]  key_return_inputs;
  logic        external_interrupt_input, ext_irq_request;
  logic        analog_input_channel;
  int          miscompares = 0, cmp_count = 0, cyc = 0, irq_n = 0, n0;
  logic [15:0] ri [6] = '{gpp_pkg::IDX_DIR0, gpp_pkg::IDX_DIR1,
    gpp_pkg::IDX_DIR4, gpp_pkg::IDX_DIR6, gpp_pkg::IDX_PULL, gpp_pkg::IDX_SEG};
  logic [7:0]  rv [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};

  gpp_top uut (.*);
  // port 0 and 1 float, port 4 and 6 held from outside
  gpp_pad #(.W(4)) p0 (.oe(port0_pin_oe), .dout(port0_pin_out),
    .pu(port0_pullup), .ext(ext), .en(1'b0), .lvl(port0_pin_in));
  gpp_pad #(.W(2)) p1 (.oe(port1_pin_oe), .dout(port1_pin_out),
    .pu(port1_pullup), .ext(ext[1:0]), .en(1'b0), .lvl(port1_pin_in));
  gpp_pad #(.W(4)) p4 (.oe(port4_pin_oe), .dout(port4_pin_out),
    .pu(port4_pullup), .ext(ext), .en(1'b1), .lvl(port4_pin_in));
  gpp_pad #(.W(2)) p6 (.oe(port6_pin_oe), .dout(port6_pin_out),
    .pu(2'h0), .ext(ext[1:0]), .en(1'b1), .lvl(port6_pin_in));

  always #5 clock = ~clock;
  // request pulses and hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (ext_irq_request === 1'b1) irq_n <= irq_n + 1;
    if (cyc == 4000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] d,
                    input logic [1:0] r = gpp_pkg::RESP_OKAY);
    @(posedge clock);
    awaddr  <= {i, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(r));
  endtask

  task automatic rd(input logic [15:0] i, input logic [7:0] d,
                    input logic [1:0] r = gpp_pkg::RESP_OKAY);
    @(posedge clock);
    araddr  <= {i, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, {24'h0, d});
    chk(32'(rresp), 32'(r));
  endtask

  task end_of_test;
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    for (int k = 0; k < 6; k++) rd(ri[k], rv[k]);
    wr(gpp_pkg::IDX_PULL, 8'h13);
    wr(gpp_pkg::IDX_LAT0, 8'h03);
    wr(gpp_pkg::IDX_DIR0, 8'h5a);
    rd(gpp_pkg::IDX_DIR0, 8'hfa);
    chk(32'(port0_pin_oe), 32'h5);
    chk(32'(port0_pullup), 32'ha);
    repeat (3) @(posedge clock);
    rd(gpp_pkg::IDX_LAT0, 8'h0b);
    wr(gpp_pkg::IDX_LAT0, 8'h0c);
    chk(32'(port0_pin_out & port0_pin_oe), 32'h4);
    wr(gpp_pkg::IDX_DIR0, 8'h00);
    rd(gpp_pkg::IDX_LAT0, 8'h0c);
    chk(32'(port0_pullup), 32'h0);
    wr(gpp_pkg::IDX_DIR1, 8'hfe);
    rd(gpp_pkg::IDX_DIR1, 8'hfe);
    chk(32'(port1_pullup), 32'h2);
    wr(gpp_pkg::IDX_PULL, 8'h01);
    wstrb <= 4'h0;
    wr(gpp_pkg::IDX_PULL, 8'h10);
    wstrb <= 4'h1;
    rd(gpp_pkg::IDX_PULL, 8'h01);
    chk(32'(port1_pullup | port4_pullup), 32'h0);
    chk(32'(key_return_inputs), 32'h9);
    rd(gpp_pkg::IDX_LAT4, 8'h09);
    // ce low freezes the pin path
    ce  <= 1'b0;
    ext <= 4'h6;
    repeat (4) @(posedge clock);
    chk(32'(key_return_inputs), 32'h9);
    ce  <= 1'b1;
    repeat (4) @(posedge clock);
    chk(32'(key_return_inputs), 32'h6);
    wr(16'hff30, 8'h00, gpp_pkg::RESP_SLVERR);
    rd(16'hff30, 8'h00, gpp_pkg::RESP_SLVERR);
    wr(gpp_pkg::IDX_DIR6, 8'hfc);
    timer_output_pin <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    chk(32'(port6_pin_out[0]), 32'h1);
    n0 = irq_n;
    wr(gpp_pkg::IDX_LAT6, 8'h02);
    repeat (3) @(posedge clock);
    chk(irq_n - n0, 32'h1);
    analog_select_bit <= 1'b1;
    repeat (4) @(posedge clock);
    chk(32'(analog_input_channel), 32'h1);
    wr(gpp_pkg::IDX_SEG, 8'hff);
    rd(gpp_pkg::IDX_SEG, 8'h3f);
    chk(32'(port8_pin_oe), 32'h3f);
    chk(32'(port8_pin_out), 32'h15);
    rd(gpp_pkg::IDX_PORT8, 8'h2a);
    port8_pin_in <= 6'h15;
    segment_data <= 6'h2a;
    repeat (2) @(posedge clock);
    chk(32'(port8_pin_out), 32'h2a);
    rd(gpp_pkg::IDX_PORT8, 8'h15);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
